// ==== logic/gisc_top.sv ====
// Summary of operation
// RL1 - intercepted external interrupt exits, stays pending
// RL2 - exception intercepts never apply to interrupts
// RL3 - smi exit: info1 bit0 external one, trap zero
// RL4 - smi during io: io info, valid, rip
// RL5 - smi intercept ignored while lock set
// RL6 - virtual interrupt exit leaves interrupt untaken
// RL7 - task intercept checked after validation, before switch
// RL8 - task switch uses only its own bit
// RL9 - task exit: selector and error code saved
// RL10 - task exit: return, jump, error, resume flags
// RL11 - ferr freeze intercept under legacy error handling
// RL12 - intercepted shutdown becomes exit instead
// RL13 - entry loads pause count, decrement, exit zero
// RL14 - zero pause count exits every pause; in threshold mode a long-gap pause reloads the count and does not exit
// RL15 - threshold mode reloads on long gap
// RL16 - zero threshold falls back to count mode
// RL17 - gap equal to threshold counts as short
// RL18 - cache owner matched by block address only
// RL19 - clear hint forces memory, set only permits
// RL20 - no address match treats hints as zero
// RL21 - hint bits map to twelve groups, rest reserved
// RL22 - hypervisor clears hints it modifies or moves
// RL23 - uncached fields always load from memory
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`include "gisc_defines.svh"

module gisc_top #(
	parameter int CNT_W       = 16,
	parameter int CACHE_DEPTH = 4
) (
	input  wire logic                     core_clk_i,
	input  wire logic                     sys_rst_i,
	input  wire logic                     psel_i,
	input  wire logic                     penable_i,
	input  wire logic                     pwrite_i,
	input  wire logic [11:0]              paddr_i,
	input  wire logic [31:0]              pwdata_i,
	output logic [31:0]                   prdata_o,
	output logic                          pready_o,
	output logic                          pslverr_o,
	input  wire logic                     entry_i,
	input  wire gisc_pkg::gisc_evt_type   evt_i,
	input  wire gisc_pkg::gisc_task_type  task_i,
	output gisc_pkg::gisc_exit_type       exit_o,
	output logic                          intr_hold_o,
	output logic                          smi_take_o,
	output logic                          shutdown_o,
	output logic                          task_go_o,
	output logic                          vintr_take_o,
	output logic                          freeze_o,
	output logic [`GISC_HINT_W-1:0]       load_cache_o,
	output logic                          load_strobe_o,
	output logic                          in_guest_o
);

	localparam int PTR_W = $clog2(CACHE_DEPTH);

	gisc_pkg::gisc_mode_type mode_q;
	gisc_pkg::gisc_mode_type mode_d;
	gisc_pkg::gisc_exit_type exit_q;
	gisc_pkg::gisc_exit_type exit_d;
	logic [31:0]             ctrl_q;
	logic [31:0]             pause_q;
	logic [31:0]             hcfg_q;
	logic [31:0]             cbaddr_q;
	logic [31:0]             hints_q;
	logic [31:0]             rdata_q;
	logic                    rdy_q;
	logic                    err_q;
	logic                    intr_hold_q;
	logic                    smi_take_q;
	logic                    shut_q;
	logic                    task_go_q;
	logic                    vintr_take_q;
	logic                    freeze_q;
	logic [`GISC_HINT_W-1:0] load_q;
	logic                    load_stb_q;
	logic [31:0]             run_addr_q;
	logic                    run_hit_q;
	logic [31:0]             tag_q [CACHE_DEPTH];
	logic [CACHE_DEPTH-1:0]  tval_q;
	logic [PTR_W-1:0]        ptr_q;
	logic [CACHE_DEPTH-1:0]  hit_vec;
	logic                    pf_trip;
	logic [CNT_W-1:0]        pf_cnt;
	logic [63:0]             smi_i1;
	logic [63:0]             smi_i2;
	logic [63:0]             ts_i2;

	// ****************************************
	// apb decode
	// ****************************************
	wire setup   = psel_i && !penable_i;
	wire wr_en   = psel_i && penable_i && pwrite_i && rdy_q;
	wire s_ctrl  = paddr_i == `GISC_OFS_CTRL;
	wire s_pause = paddr_i == `GISC_OFS_PAUSE;
	wire s_hcfg  = paddr_i == `GISC_OFS_HCFG;
	wire s_cba   = paddr_i == `GISC_OFS_CBADDR;
	wire s_code  = paddr_i == `GISC_OFS_CODE;
	wire s_i1lo  = paddr_i == `GISC_OFS_I1LO;
	wire s_i1hi  = paddr_i == `GISC_OFS_I1HI;
	wire s_i2lo  = paddr_i == `GISC_OFS_I2LO;
	wire s_i2hi  = paddr_i == `GISC_OFS_I2HI;
	wire s_stat  = paddr_i == `GISC_OFS_STAT;
	wire s_hints = paddr_i == `GISC_OFS_HINTS;
	wire mapped  = s_ctrl || s_pause || s_hcfg || s_cba || s_code || s_i1lo ||
		s_i1hi || s_i2lo || s_i2hi || s_stat || s_hints;
	wire in_guest = mode_q == gisc_pkg::GISC_GUEST;
	// status word: load groups, shutdown, held interrupt, guest mode
	wire [31:0] stat = {4'h0, load_q, 13'h0000, shut_q, intr_hold_q, in_guest};
	wire [31:0] rmux = s_ctrl ? ctrl_q :
		s_pause ? pause_q :
		s_hcfg  ? hcfg_q :
		s_cba   ? cbaddr_q :
		s_code  ? {28'h0000000, exit_q.code} :
		s_i1lo  ? exit_q.info1[31:0] :
		s_i1hi  ? exit_q.info1[63:32] :
		s_i2lo  ? exit_q.info2[31:0] :
		s_i2hi  ? exit_q.info2[63:32] :
		s_stat  ? stat :
		s_hints ? hints_q : 32'h0000_0000;

	// ****************************************
	// apb slave: answer registered in the setup cycle
	// ****************************************
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			rdy_q   <= 1'b0;
			err_q   <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			rdy_q   <= setup;
			err_q   <= setup && !mapped;
			rdata_q <= (setup && !pwrite_i) ? rmux : 32'h0000_0000;
		end
	end

	// software registers; the core never writes the hints back
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			ctrl_q   <= `GISC_CTRL_RST;
			pause_q  <= `GISC_PAUSE_RST;
			hcfg_q   <= `GISC_HCFG_RST;
			cbaddr_q <= `GISC_CBADDR_RST;
			hints_q  <= `GISC_HINTS_RST;
		end else if (wr_en) begin
			if (s_ctrl) ctrl_q <= pwdata_i;
			if (s_pause) pause_q <= pwdata_i;
			if (s_hcfg) hcfg_q <= pwdata_i;
			if (s_cba) cbaddr_q <= pwdata_i;
			if (s_hints) hints_q <= pwdata_i;
		end
	end

	// ****************************************
	// intercept qualification, guest mode only
	// ****************************************
	wire smi_any  = evt_i.smi_ext || evt_i.smi_io;
	wire smi_lock = hcfg_q[`GISC_HCFG_LOCK];
	wire ferr_frz = evt_i.ferr && !evt_i.ign_nerr && !evt_i.ne_mode;       // RL11
	wire h_shut   = in_guest && evt_i.shutdown && ctrl_q[`GISC_EN_SHUT];    // RL12
	wire h_smi    = in_guest && smi_any && ctrl_q[`GISC_EN_SMI] && !smi_lock; // RL5
	wire h_nmi    = in_guest && evt_i.nmi && ctrl_q[`GISC_EN_NMI];
	// interrupts look only at their own bit, whatever the vector
	wire h_intr   = in_guest && evt_i.ext_intr && ctrl_q[`GISC_EN_INTR];    // RL1 RL2
	wire h_ferr   = in_guest && ferr_frz && ctrl_q[`GISC_EN_FERR];          // RL11
	// task request arrives already validated; only one bit consulted
	wire h_task   = in_guest && task_i.req && ctrl_q[`GISC_EN_TASK];        // RL7 RL8
	wire h_vintr  = in_guest && evt_i.vintr_accept && ctrl_q[`GISC_EN_VINTR]; // RL6
	wire h_pause  = in_guest && pf_trip && ctrl_q[`GISC_EN_PAUSE];          // RL13 RL14

	// fixed priority, one exit per cycle
	wire [3:0] xcode = h_shut ? `GISC_X_SHUT :
		h_smi   ? `GISC_X_SMI :
		h_nmi   ? `GISC_X_NMI :
		h_intr  ? `GISC_X_INTR :
		h_ferr  ? `GISC_X_FERR :
		h_task  ? `GISC_X_TASK :
		h_vintr ? `GISC_X_VINTR :
		h_pause ? `GISC_X_PAUSE : `GISC_X_NONE;
	wire xany = xcode != `GISC_X_NONE;

	// ****************************************
	// exit information words
	// ****************************************
	always_comb begin
		smi_i1 = 64'h0;
		smi_i2 = 64'h0;
		smi_i1[`GISC_I1_SMI_EXT] = evt_i.smi_ext;                          // RL3
		if (evt_i.smi_in_io) begin
			smi_i1[`GISC_I1_IO_LSB +: 32] = evt_i.io_info;                  // RL4
			smi_i1[`GISC_I1_IO_VAL] = 1'b1;                                 // RL4
			smi_i2[31:0] = evt_i.io_rip;                                    // RL4
		end
	end

	always_comb begin
		ts_i2 = 64'h0;
		ts_i2[31:0] = task_i.has_err ? task_i.err : 32'h0000_0000;         // RL9
		ts_i2[`GISC_I2_IRTN] = task_i.irtn;                                // RL10
		ts_i2[`GISC_I2_JMP] = task_i.jmp;                                  // RL10
		ts_i2[`GISC_I2_HASERR] = task_i.has_err;                           // RL10
		ts_i2[`GISC_I2_RF] = task_i.rf;                                    // RL10
	end

	// shutdown leaves the saved information zero (content undefined)
	assign exit_d.valid = xany;
	assign exit_d.code  = xcode;
	assign exit_d.info1 = (xcode == `GISC_X_SMI) ? smi_i1 :
		(xcode == `GISC_X_TASK) ? {48'h0, task_i.sel} : 64'h0;             // RL9
	assign exit_d.info2 = (xcode == `GISC_X_SMI) ? smi_i2 :
		(xcode == `GISC_X_TASK) ? ts_i2 : 64'h0;

	// ****************************************
	// state cache lookup by control block address
	// ****************************************
	for (genvar i = 0; i < CACHE_DEPTH; i++) begin : g_cmp
		assign hit_vec[i] = tval_q[i] && (tag_q[i] == cbaddr_q);       // RL18
	end
	wire hit_any = |hit_vec;
	// a miss behaves as if every hint were clear
	wire [`GISC_HINT_W-1:0] eff_hint = hit_any ?
		hints_q[`GISC_HINT_W-1:0] : '0;                                // RL19 RL20 RL21
	// the uncached fields (flush command, shadow, status, injection,
	// flags, pointers, accumulator) have no bit here and always
	// come from memory
	wire [`GISC_HINT_W-1:0] load_d = eff_hint;                         // RL23

	// ****************************************
	// mode machine
	// ****************************************
	always_comb begin
		mode_d = mode_q;
		case (mode_q)
			gisc_pkg::GISC_HOST: begin
				if (entry_i) mode_d = gisc_pkg::GISC_GUEST;
			end
			gisc_pkg::GISC_GUEST: begin
				if (xany) mode_d = gisc_pkg::GISC_HOST;
			end
			default: mode_d = gisc_pkg::GISC_HOST;
		endcase
	end
	wire entering = (mode_q == gisc_pkg::GISC_HOST) && entry_i;

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			mode_q     <= gisc_pkg::GISC_HOST;
			exit_q     <= '0;
			load_q     <= '0;
			load_stb_q <= 1'b0;
			run_addr_q <= 32'h0000_0000;
			run_hit_q  <= 1'b0;
		end else begin
			mode_q     <= mode_d;
			exit_q     <= exit_d;
			load_stb_q <= entering;
			if (entering) begin
				load_q     <= load_d;
				run_addr_q <= cbaddr_q;
				run_hit_q  <= hit_any;
			end
		end
	end

	// ****************************************
	// cache fill on exit, round robin; depth must be a power of two
	// ****************************************
	wire fill = in_guest && xany && !run_hit_q;
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			tval_q <= '0;
			ptr_q  <= '0;
		end else if (fill) begin
			tval_q[ptr_q] <= 1'b1;
			ptr_q         <= ptr_q + 1'b1;
		end
	end

	// tag storage carries no reset: valid bits guard it
	always_ff @(posedge core_clk_i) begin
		if (fill) tag_q[ptr_q] <= run_addr_q;
	end

	// ****************************************
	// side effects towards the core
	// ****************************************
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			intr_hold_q  <= 1'b0;
			smi_take_q   <= 1'b0;
			shut_q       <= 1'b0;
			task_go_q    <= 1'b0;
			vintr_take_q <= 1'b0;
			freeze_q     <= 1'b0;
		end else begin
			// set beats the release by the interrupt going away
			intr_hold_q  <= (xcode == `GISC_X_INTR) ||
				(intr_hold_q && evt_i.ext_intr);                        // RL1
			smi_take_q   <= smi_any && !h_smi;                           // RL5
			shut_q       <= shut_q || (evt_i.shutdown && !h_shut);       // RL12
			task_go_q    <= task_i.req && !h_task;                       // RL7
			vintr_take_q <= evt_i.vintr_accept && !h_vintr;              // RL6
			freeze_q     <= ferr_frz && !h_ferr;
		end
	end

	// ****************************************
	// pause filter
	// ****************************************
	gisc_pause_filter #(
		.CNT_W(CNT_W)
	) u_pf (
		.core_clk_i(core_clk_i),
		.sys_rst_i (sys_rst_i),
		.load_i    (entering),
		.pause_i   (in_guest && evt_i.pause),
		.count_i   (pause_q[`GISC_PCNT_LSB +: CNT_W]),
		.thr_i     (pause_q[`GISC_PTHR_LSB +: CNT_W]),
		.thr_sup_i (ctrl_q[`GISC_EN_THRSUP]),
		.trip_o    (pf_trip),
		.cnt_o     (pf_cnt)
	);

	// ****************************************
	// outputs
	// ****************************************
	assign prdata_o      = rdata_q;
	assign pready_o      = rdy_q;
	assign pslverr_o     = err_q;
	assign exit_o        = exit_q;
	assign intr_hold_o   = intr_hold_q;
	assign smi_take_o    = smi_take_q;
	assign shutdown_o    = shut_q;
	assign task_go_o     = task_go_q;
	assign vintr_take_o  = vintr_take_q;
	assign freeze_o      = freeze_q;
	assign load_cache_o  = load_q;
	assign load_strobe_o = load_stb_q;
	assign in_guest_o    = mode_q[1]; // guest bit of the one-hot state flop

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (sys_rst_i);

	sequence s_intr_exit;
		exit_o.valid && exit_o.code == `GISC_X_INTR;
	endsequence

	intr_hold_a: assert property (h_intr && !h_shut && !h_smi && !h_nmi // RL1
		|=> s_intr_exit ##0 intr_hold_o)
		else $error("intercepted interrupt not held");

	smi_lock_a: assert property (exit_o.valid && exit_o.code == `GISC_X_SMI // RL5
		|-> !$past(hcfg_q[`GISC_HCFG_LOCK]))
		else $error("smi exit while lock set");

	smi_src_a: assert property (exit_o.valid && exit_o.code == `GISC_X_SMI // RL3
		|-> exit_o.info1[`GISC_I1_SMI_EXT] == $past(evt_i.smi_ext))
		else $error("smi source bit wrong");

	smi_io_a: assert property (h_smi && !h_shut && evt_i.smi_in_io // RL4
		|=> exit_o.info1[`GISC_I1_IO_VAL] && exit_o.info2[31:0] == $past(evt_i.io_rip))
		else $error("smi io information missing");

	task_info_a: assert property (exit_o.valid && exit_o.code == `GISC_X_TASK // RL9
		|-> exit_o.info1[15:0] == $past(task_i.sel) &&
		exit_o.info2[`GISC_I2_HASERR] == $past(task_i.has_err))
		else $error("task exit information wrong");

	vintr_keep_a: assert property (h_vintr // RL6
		|=> !vintr_take_o)
		else $error("intercepted virtual interrupt taken");

	ferr_mode_a: assert property (evt_i.ferr && (evt_i.ign_nerr || evt_i.ne_mode) // RL11
		|=> !(exit_o.valid && exit_o.code == `GISC_X_FERR))
		else $error("ferr exit outside legacy freeze");

	shut_exit_a: assert property (in_guest && evt_i.shutdown // RL12
		|=> (exit_o.valid && exit_o.code == `GISC_X_SHUT) != shutdown_o)
		else $error("shutdown neither exited nor taken");

	pause_zero_a: assert property (in_guest && evt_i.pause && pf_cnt == '0 // RL14
		&& ctrl_q[`GISC_EN_PAUSE] && xcode == `GISC_X_PAUSE
		|=> exit_o.valid ##1 !in_guest_o)
		else $error("pause at zero count did not exit");

	hint_miss_a: assert property ($rose(load_strobe_o) && !run_hit_q // RL20
		|-> load_cache_o == '0)
		else $error("hints used on cache miss");

	hint_only_a: assert property (load_strobe_o // RL19
		|-> (load_cache_o & ~$past(hints_q[`GISC_HINT_W-1:0])) == '0)
		else $error("clear hint loaded from cache");

endmodule // gisc_top

// ==== logic/gisc_defines.svh ====
`ifndef GISC_DEFINES_SVH
`define GISC_DEFINES_SVH

// ****************************************
// register byte offsets (apb, 32-bit words)
// ****************************************
`define GISC_OFS_CTRL   12'h000
`define GISC_OFS_PAUSE  12'h004
`define GISC_OFS_HCFG   12'h008
`define GISC_OFS_CBADDR 12'h00c
`define GISC_OFS_CODE   12'h010
`define GISC_OFS_I1LO   12'h014
`define GISC_OFS_I1HI   12'h018
`define GISC_OFS_I2LO   12'h01c
`define GISC_OFS_I2HI   12'h020
`define GISC_OFS_STAT   12'h024
`define GISC_OFS_HINTS  12'h0c0

// ****************************************
// reset values
// ****************************************
`define GISC_CTRL_RST   32'h0000_0000
`define GISC_PAUSE_RST  32'h0000_0000
`define GISC_HCFG_RST   32'h0000_0000
`define GISC_CBADDR_RST 32'h0000_0000
`define GISC_HINTS_RST  32'h0000_0000

// ****************************************
// control word bits (intercept enables, threshold support), then the lock bit of hcfg
// ****************************************
`define GISC_EN_INTR    0
`define GISC_EN_NMI     1
`define GISC_EN_SMI     2
`define GISC_EN_VINTR   3
`define GISC_EN_TASK    4
`define GISC_EN_FERR    5
`define GISC_EN_SHUT    6
`define GISC_EN_PAUSE   7
`define GISC_EN_THRSUP  8
`define GISC_HCFG_LOCK  0

// ****************************************
// pause configuration fields
// ****************************************
`define GISC_PCNT_LSB   0
`define GISC_PTHR_LSB   16

// ****************************************
// exit codes
// ****************************************
`define GISC_X_NONE     4'h0
`define GISC_X_INTR     4'h1
`define GISC_X_NMI      4'h2
`define GISC_X_SMI      4'h3
`define GISC_X_VINTR    4'h4
`define GISC_X_TASK     4'h5
`define GISC_X_FERR     4'h6
`define GISC_X_SHUT     4'h7
`define GISC_X_PAUSE    4'h8

// ****************************************
// exit information bit positions
// ****************************************
`define GISC_I1_SMI_EXT 0
`define GISC_I1_IO_LSB  32
`define GISC_I1_IO_VAL  32
`define GISC_I2_IRTN    36
`define GISC_I2_JMP     38
`define GISC_I2_HASERR  44
`define GISC_I2_RF      48

// ****************************************
// clean hint groups, bits 31:12 reserved
// ****************************************
`define GISC_HINT_W     12
`define GISC_H_INTCP    0
`define GISC_H_IOMAP    1
`define GISC_H_ASTAG    2
`define GISC_H_VPRIO    3
`define GISC_H_NPAGE    4
`define GISC_H_CTRLR    5
`define GISC_H_DEBUG    6
`define GISC_H_DTAB     7
`define GISC_H_SEG      8
`define GISC_H_FADDR    9
`define GISC_H_BRREC    10
`define GISC_H_VAPIC    11

`endif

// ==== logic/gisc_pkg.sv ====
package gisc_pkg;

	// ****************************************
	// mode of the core as seen by this block
	// ****************************************
	typedef enum logic [1:0] {
		GISC_HOST  = 2'b01,
		GISC_GUEST = 2'b10
	} gisc_mode_type;

	// events offered by the core, same clock
	typedef struct packed {
		logic        ext_intr;
		logic        nmi;
		logic        smi_ext;
		logic        smi_io;
		logic        smi_in_io;
		logic [31:0] io_info;
		logic [31:0] io_rip;
		logic        vintr_accept;
		logic        ferr;
		logic        ign_nerr;
		logic        ne_mode;
		logic        shutdown;
		logic        pause;
	} gisc_evt_type;

	// a task switch that has passed its segment and gate checks
	typedef struct packed {
		logic        req;
		logic        irtn;
		logic        jmp;
		logic        has_err;
		logic        rf;
		logic [15:0] sel;
		logic [31:0] err;
	} gisc_task_type;

	typedef struct packed {
		logic        valid;
		logic [3:0]  code;
		logic [63:0] info1;
		logic [63:0] info2;
	} gisc_exit_type;

endpackage

// ==== logic/gisc_pause_filter.sv ====
`timescale 1ns/1ps
`include "gisc_defines.svh"

module gisc_pause_filter #(
	parameter int CNT_W = 16
) (
	input  wire logic             core_clk_i,
	input  wire logic             sys_rst_i,
	input  wire logic             load_i,
	input  wire logic             pause_i,
	input  wire logic [CNT_W-1:0] count_i,
	input  wire logic [CNT_W-1:0] thr_i,
	input  wire logic             thr_sup_i,
	output logic                  trip_o,
	output logic [CNT_W-1:0]      cnt_o
);

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic [CNT_W:0]   gap_q;
	logic [CNT_W:0]   gap_d;

	// ****************************************
	// mode and decision
	// ****************************************
	wire thr_mode = thr_sup_i && (thr_i != '0);         // RL16
	wire long_gap = gap_q > {1'b0, thr_i};              // RL15 RL17
	wire reload   = pause_i && thr_mode && long_gap;    // RL15
	wire is_zero  = cnt_q == '0;
	wire is_one   = cnt_q == {{(CNT_W-1){1'b0}}, 1'b1};
	// threshold mode trips only when the count would go below zero
	assign trip_o = pause_i && !reload &&
		(thr_mode ? is_zero : (is_zero || is_one));      // RL13 RL14 RL15
	assign cnt_o  = cnt_q;

	// counter saturates at zero so later pauses keep tripping
	assign cnt_d = (load_i || reload) ? count_i :
		(pause_i && !is_zero) ? cnt_q - 1'b1 : cnt_q;     // RL13 RL15
	// elapsed cycles since last pause, saturating
	assign gap_d = (load_i || pause_i) ? '0 :
		(&gap_q) ? gap_q : gap_q + 1'b1;

	// ****************************************
	// state
	// ****************************************
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			cnt_q <= '0;
			gap_q <= '0;
		end else begin
			cnt_q <= cnt_d;
			gap_q <= gap_d;
		end
	end

endmodule // gisc_pause_filter

// ==== tb/gisc_top_tb.sv ====
`timescale 1ns/1ps
`include "gisc_defines.svh"

module gisc_top_tb;
	// ****************************************
	// stimulus and observed ports
	// ****************************************
	logic                    core_clk_i = 1'b0;
	logic                    sys_rst_i  = 1'b1;
	logic                    psel_i     = 1'b0;
	logic                    penable_i  = 1'b0;
	logic                    pwrite_i   = 1'b0;
	logic [11:0]             paddr_i    = 12'h000;
	logic [31:0]             pwdata_i   = 32'h0000_0000;
	logic                    entry_i    = 1'b0;
	gisc_pkg::gisc_evt_type  evt_i      = '0;
	gisc_pkg::gisc_task_type task_i     = '0;
	gisc_pkg::gisc_exit_type exit_o, x;
	logic [31:0]             prdata_o, rd;
	logic [11:0]             load_cache_o;
	logic [3:0]              xc;
	logic                    pready_o, pslverr_o, intr_hold_o, smi_take_o, shutdown_o;
	logic                    task_go_o, vintr_take_o, freeze_o, load_strobe_o, in_guest_o;
	logic                    err, take;
	int                      mismatches  = 0;
	int                      comparisons = 0;

	// core clock, 10 ns period
	always #5 core_clk_i = ~core_clk_i;

	gisc_top uut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .entry_i(entry_i),
		.evt_i(evt_i), .task_i(task_i), .exit_o(exit_o), .intr_hold_o(intr_hold_o),
		.smi_take_o(smi_take_o), .shutdown_o(shutdown_o), .task_go_o(task_go_o),
		.vintr_take_o(vintr_take_o), .freeze_o(freeze_o), .load_cache_o(load_cache_o),
		.load_strobe_o(load_strobe_o), .in_guest_o(in_guest_o));

	// ****************************************
	// shared helpers
	// ****************************************
	task automatic tick();
		@(posedge core_clk_i);
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic finish_test();
		$display("compared %0d, mismatched %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// apb master: request held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		tick();
		psel_i   <= 1'b1;
		pwrite_i <= wr;
		paddr_i  <= a;
		pwdata_i <= d;
		tick();
		penable_i <= 1'b1;
		// no limit of its own: a hang is ended by the watchdog
		do begin
			tick();
		end while (pready_o !== 1'b1);
		rd  = prdata_o;
		err = pslverr_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
	endtask

	// guest entry pulse, then the group load choice
	task automatic enter(input logic [11:0] exp_ld);
		tick();
		entry_i <= 1'b1;
		tick();
		entry_i <= 1'b0;
		while (load_strobe_o !== 1'b1) begin
			tick();
		end
		chk(in_guest_o, 1'b1);
		chk(load_cache_o, exp_ld);
	endtask

	// bounded watch for an exit; none seen leaves the none code
	task automatic ev_exit();
		xc = `GISC_X_NONE;
		for (int n = 0; n < 8 && xc === `GISC_X_NONE; n++) begin
			tick();
			take |= smi_take_o | task_go_o;
			if (exit_o.valid === 1'b1) begin
				x  = exit_o;
				xc = exit_o.code;
			end
		end
	endtask

	// one-cycle event, then watch
	task automatic fire();
		tick();
		evt_i  <= '0;
		task_i <= '0;
		ev_exit();
	endtask

	task automatic pz(input int n);
		repeat (n) tick();
		evt_i.pause <= 1'b1;
		tick();
		evt_i.pause <= 1'b0;
	endtask

	// interrupt held high across the exit so it stays pending
	task automatic intr_exit();
		evt_i.ext_intr <= 1'b1;
		ev_exit();
		chk(xc, `GISC_X_INTR);
		tick();
		chk(intr_hold_o, 1'b1);
		evt_i.ext_intr <= 1'b0;
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_regs();
		apb(1'b0, `GISC_OFS_HINTS, 32'h0);
		chk(rd, `GISC_HINTS_RST);
		apb(1'b0, 12'h100, 32'h0);
		chk({err, rd}, 33'h1_0000_0000);
		apb(1'b1, `GISC_OFS_HINTS, 32'hffff_ffff);
		apb(1'b0, `GISC_OFS_HINTS, 32'h0);
		chk(rd, 32'hffff_ffff);
		$display("registers done");
	endtask

	// miss, hit, move to a new block address, cleared hints
	task automatic t_cache();
		apb(1'b1, `GISC_OFS_CBADDR, 32'h0000_1000);
		apb(1'b1, `GISC_OFS_CTRL, 32'h1 << `GISC_EN_INTR);
		enter(12'h000);
		intr_exit();
		enter(12'hfff);
		intr_exit();
		apb(1'b1, `GISC_OFS_CBADDR, 32'h0000_2000);
		enter(12'h000);
		intr_exit();
		apb(1'b1, `GISC_OFS_HINTS, 32'h0);
		enter(12'h000);
		intr_exit();
		$display("cache done");
	endtask

	task automatic t_smi();
		apb(1'b1, `GISC_OFS_CTRL, 32'h0000_0006);
		enter(12'h000);
		evt_i.smi_ext   <= 1'b1;
		evt_i.smi_in_io <= 1'b1;
		evt_i.io_info   <= 32'h5a5a_0001;
		evt_i.io_rip    <= 32'h1234_5678;
		fire();
		chk(xc, `GISC_X_SMI);
		chk(x.info1[31:0], 32'h1);
		chk(x.info1[63:32], 32'h5a5a_0001);
		chk(x.info2[31:0], 32'h1234_5678);
		enter(12'h000);
		evt_i.smi_io <= 1'b1;
		fire();
		chk({xc, x.info1[0]}, {`GISC_X_SMI, 1'b0});
		apb(1'b1, `GISC_OFS_HCFG, 32'h1);
		enter(12'h000);
		take = 1'b0;
		evt_i.smi_ext <= 1'b1;
		fire();
		chk({xc, take}, {`GISC_X_NONE, 1'b1});
		evt_i.nmi <= 1'b1;
		fire();
		chk(xc, `GISC_X_NMI);
		apb(1'b1, `GISC_OFS_HCFG, 32'h0);
		$display("smi done");
	endtask

	task automatic t_misc();
		int          en[4] = '{`GISC_EN_VINTR, `GISC_EN_FERR, `GISC_EN_SHUT, `GISC_EN_NMI};
		logic [3:0]  cd[4] = '{`GISC_X_VINTR, `GISC_X_FERR, `GISC_X_SHUT, `GISC_X_NMI};
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, `GISC_OFS_CTRL, 32'h1 << en[i]);
			enter(12'h000);
			case (i)
				0: evt_i.vintr_accept <= 1'b1;
				1: evt_i.ferr <= 1'b1;
				2: evt_i.shutdown <= 1'b1;
				default: evt_i.nmi <= 1'b1;
			endcase
			fire();
			chk({xc, vintr_take_o, shutdown_o, freeze_o}, {cd[i], 3'b000});
		end
		$display("misc done");
	endtask

	task automatic t_task();
		apb(1'b1, `GISC_OFS_CTRL, 32'h1 << `GISC_EN_TASK);
		enter(12'h000);
		task_i <= {1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0048, 32'h0000_0abc};
		fire();
		chk(xc, `GISC_X_TASK);
		chk({x.info1[15:0], x.info2[31:0]}, 48'h0048_0000_0abc);
		chk({x.info2[48], x.info2[44], x.info2[38], x.info2[36]}, 4'b1101);
		enter(12'h000);
		task_i <= {1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0050, 32'h0};
		fire();
		chk({x.info2[48], x.info2[44], x.info2[38], x.info2[36]}, 4'b0010);
		// every other intercept on, task switch proceeds
		apb(1'b1, `GISC_OFS_CTRL, 32'h0000_01ef);
		enter(12'h000);
		take = 1'b0;
		task_i <= {1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0058, 32'h0};
		// ferr with modern error handling must not freeze or exit
		evt_i.ferr    <= 1'b1;
		evt_i.ne_mode <= 1'b1;
		fire();
		chk({xc, take}, {`GISC_X_NONE, 1'b1});
		evt_i.nmi <= 1'b1;
		fire();
		chk(xc, `GISC_X_NMI);
		$display("task done");
	endtask

	task automatic t_pause();
		apb(1'b1, `GISC_OFS_CTRL, 32'h1 << `GISC_EN_PAUSE);
		apb(1'b1, `GISC_OFS_PAUSE, 32'h0000_0002);
		enter(12'h000);
		pz(1);
		ev_exit();
		chk(xc, `GISC_X_NONE);
		pz(1);
		ev_exit();
		chk(xc, `GISC_X_PAUSE);
		apb(1'b1, `GISC_OFS_PAUSE, 32'h0);
		enter(12'h000);
		pz(1);
		ev_exit();
		chk(xc, `GISC_X_PAUSE);
		apb(1'b1, `GISC_OFS_CTRL, 32'h0000_0180);
		apb(1'b1, `GISC_OFS_PAUSE, 32'h0000_0001);
		enter(12'h000);
		pz(1);
		ev_exit();
		chk(xc, `GISC_X_PAUSE);
		// short, long gap reload, gap equal to threshold, then short
		apb(1'b1, `GISC_OFS_PAUSE, 32'h0004_0001);
		enter(12'h000);
		pz(1);
		pz(10);
		pz(4);
		pz(1);
		ev_exit();
		chk(xc, `GISC_X_PAUSE);
		$display("pause done");
	endtask

	// reset three cycles, then every scenario in turn
	initial begin
		repeat (3) tick();
		sys_rst_i <= 1'b0;
		t_regs();
		t_cache();
		t_smi();
		t_misc();
		t_task();
		t_pause();
		finish_test();
	end

	// watchdog: the run needs a few hundred cycles
	initial begin
		#200000;
		mismatches++;
		finish_test();
	end
endmodule // gisc_top_tb
